/* verilog/bmsd_params.svh */
`ifndef BMSD_PARAMS_SVH
`define BMSD_PARAMS_SVH

`define BMSD_CFG_ASC_LOADER   4'h0
`define BMSD_CFG_CAN_LOADER   4'h1
`define BMSD_CFG_FLASH        4'h2
`define BMSD_CFG_FLASH_ALT    4'h3
`define BMSD_CFG_EXT_MASTER   4'h4
`define BMSD_CFG_EXT_MST_ALT  4'h5
`define BMSD_CFG_EXT_PART     4'h6
`define BMSD_CFG_EXT_PRT_ALT  4'h7
`define BMSD_CFG_EMULATION    4'h8
`define BMSD_CFG_ASC_ON_CAN   4'hF

`define BMSD_ADDR_LOADER      32'hD4000000
`define BMSD_ADDR_FLASH       32'hA0000000
`define BMSD_ADDR_EXTMEM      32'hA1000000
`define BMSD_ADDR_EMUMEM      32'hAFF00000
`define BMSD_ADDR_EMUSPACE    32'hDE000000
`define BMSD_ADDR_NONE        32'h00000000

`define BMSD_BUS_CFG_OFFSET   32'h00000004

`define BMSD_OPT_WIDTH        3

`endif

/* verilog/bmsd_pkg.sv */
package bmsd_pkg;

  typedef enum logic [9:0] {
    BMSD_IDLE     = 10'h001,
    BMSD_LOADER1  = 10'h002,
    BMSD_LOADER2  = 10'h004,
    BMSD_LOADER3  = 10'h008,
    BMSD_FLASH    = 10'h010,
    BMSD_EXTMEM   = 10'h020,
    BMSD_EMUMEM   = 10'h040,
    BMSD_EMUSPACE = 10'h080,
    BMSD_TRISTATE = 10'h100,
    BMSD_STOP     = 10'h200
  } bmsd_boot_t;

  typedef struct packed {
    logic       crcCheck;
    logic       busAutoCfg;
    logic       busMaster;
    logic       busParticipant;
    logic       chipSelectZero;
    logic       emulatorChipSelect;
    logic [2:0] fallbackLoader;
  } bmsd_ctrl_t;

endpackage

/* verilog/bmsd_capture.sv */
`timescale 1ns/1ps
`include "bmsd_params.svh"

module bmsd_capture (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       breakInput,
  input  wire logic [3:0] hardwareConfigPins,
  input  wire logic [2:0] port0Pins,
  output logic            captured,
  output logic            breakLevel,
  output logic [3:0]      configCode,
  output logic [2:0]      softwareOptionField
);

  logic doneReg;

  // sample once on the first edge after release; pins may move afterwards
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      doneReg             <= 1'b0;
      breakLevel          <= 1'b0;
      configCode          <= 4'h0;
      softwareOptionField <= 3'h0;
    end else if (!doneReg) begin
      doneReg             <= 1'b1;
      breakLevel          <= breakInput;
      configCode          <= hardwareConfigPins;
      softwareOptionField <= port0Pins;
    end
  end

  assign captured = doneReg;

endmodule

/* verilog/bmsd_boot_mode_select_decoder.sv */
`timescale 1ns/1ps
`include "bmsd_params.svh"

// Summary of operation
// - break high, code 0000: serial loader 1 on async port, exit D4000000
// - break high, code 0001: serial loader 2 over the CAN pins
// - code 0011: flash alternate boot, crc check, else serial fallback at D4000000
// - code 0100: external memory, bus unit master, chip select 0, exit A1000000
// - code 0101: external alternate boot as master, crc, serial fallback on fail
// - code 0110: external memory, bus unit participant, chip select 0, A1000000
// - code 0111: external alternate boot as participant, crc, serial fallback
// - break high, code 1000: emulation memory AFF00000 if present, else stop loop
// - break high, code 1111: serial loader 3, async protocol on CAN pins
// - any unassigned code for either break level: stop loop
// - break low: 0000 tri-states outputs; 1000 jumps DE000000 via emulator select
// - crc fallback is always serial loader 1; 3-bit option field latched from port 0 pins is only passed out as fallbackLoader
// - external boot modes fetch bus configuration from offset 4 on chip select 0
module bmsd_boot_mode_select_decoder (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                breakInput,
  input  wire logic [3:0]          hardwareConfigPins,
  input  wire logic [2:0]          port0Pins,
  input  wire logic                emulationPresent,
  input  wire logic                crcDone,
  input  wire logic                crcPass,
  input  wire logic [31:0]         altHeaderAddr,
  output bmsd_pkg::bmsd_boot_t     bootType,
  output bmsd_pkg::bmsd_ctrl_t     bootCtrl,
  output logic [31:0]              exitJumpAddr,
  output logic [31:0]              busConfigAddr,
  output logic                     tristateChip,
  output logic                     stopLoop,
  output logic                     crcRequest,
  output logic                     bootValid
);

  logic       captured;
  logic       breakLevel;
  logic [3:0] configCode;
  logic [2:0] softwareOptionField;

  bmsd_capture uCapture (
    .clk                 (clk),
    .rstn                (rstn),
    .breakInput          (breakInput),
    .hardwareConfigPins  (hardwareConfigPins),
    .port0Pins           (port0Pins),
    .captured            (captured),
    .breakLevel          (breakLevel),
    .configCode          (configCode),
    .softwareOptionField (softwareOptionField)
  );

  function automatic bmsd_pkg::bmsd_boot_t decodeBoot(input logic brk, input logic [3:0] code, input logic emu);
    bmsd_pkg::bmsd_boot_t t;
    t = bmsd_pkg::BMSD_STOP;
    if (brk) begin
      unique case (code)
        `BMSD_CFG_ASC_LOADER:  t = bmsd_pkg::BMSD_LOADER1;
        `BMSD_CFG_CAN_LOADER:  t = bmsd_pkg::BMSD_LOADER2;
        `BMSD_CFG_FLASH,
        `BMSD_CFG_FLASH_ALT:   t = bmsd_pkg::BMSD_FLASH;
        `BMSD_CFG_EXT_MASTER,
        `BMSD_CFG_EXT_MST_ALT,
        `BMSD_CFG_EXT_PART,
        `BMSD_CFG_EXT_PRT_ALT: t = bmsd_pkg::BMSD_EXTMEM;
        `BMSD_CFG_EMULATION:   t = emu ? bmsd_pkg::BMSD_EMUMEM : bmsd_pkg::BMSD_STOP;
        `BMSD_CFG_ASC_ON_CAN:  t = bmsd_pkg::BMSD_LOADER3;
        default:               t = bmsd_pkg::BMSD_STOP;
      endcase
    end else begin
      unique case (code)
        `BMSD_CFG_ASC_LOADER:  t = bmsd_pkg::BMSD_TRISTATE;
        `BMSD_CFG_EMULATION:   t = bmsd_pkg::BMSD_EMUSPACE;
        default:               t = bmsd_pkg::BMSD_STOP;
      endcase
    end
    return t;
  endfunction

  function automatic logic [31:0] exitAddrOf(input bmsd_pkg::bmsd_boot_t t);
    logic [31:0] a;
    a = `BMSD_ADDR_NONE;
    unique case (t)
      bmsd_pkg::BMSD_LOADER1,
      bmsd_pkg::BMSD_LOADER2,
      bmsd_pkg::BMSD_LOADER3: a = `BMSD_ADDR_LOADER;
      bmsd_pkg::BMSD_FLASH:    a = `BMSD_ADDR_FLASH;
      bmsd_pkg::BMSD_EXTMEM:   a = `BMSD_ADDR_EXTMEM;
      bmsd_pkg::BMSD_EMUMEM:   a = `BMSD_ADDR_EMUMEM;
      bmsd_pkg::BMSD_EMUSPACE: a = `BMSD_ADDR_EMUSPACE;
      default:                 a = `BMSD_ADDR_NONE;
    endcase
    return a;
  endfunction

  // decoding from the held capture plus live emulationPresent, so late strap pin changes never reach the outputs
  wire bmsd_pkg::bmsd_boot_t baseType = decodeBoot(breakLevel, configCode, emulationPresent);
  wire isAlternate = breakLevel && (configCode == `BMSD_CFG_FLASH_ALT || configCode == `BMSD_CFG_EXT_MST_ALT ||
                                    configCode == `BMSD_CFG_EXT_PRT_ALT);
  wire isExternal = (baseType == bmsd_pkg::BMSD_EXTMEM);
  wire isMaster = breakLevel && (configCode == `BMSD_CFG_EXT_MASTER || configCode == `BMSD_CFG_EXT_MST_ALT);
  wire isParticipant = breakLevel && (configCode == `BMSD_CFG_EXT_PART || configCode == `BMSD_CFG_EXT_PRT_ALT);

  bmsd_pkg::bmsd_ctrl_t ctrlNext;
  always_comb begin
    ctrlNext                    = '0;
    ctrlNext.crcCheck           = isAlternate;
    ctrlNext.busAutoCfg         = isExternal;
    ctrlNext.busMaster          = isMaster || (baseType == bmsd_pkg::BMSD_EMUSPACE);
    ctrlNext.busParticipant     = isParticipant;
    ctrlNext.chipSelectZero     = isExternal;
    ctrlNext.emulatorChipSelect = (baseType == bmsd_pkg::BMSD_EMUSPACE);
    ctrlNext.fallbackLoader     = softwareOptionField;
  end

  // alternate boot waits for the crc verdict; a failure drops to the serial loader
  typedef enum logic [2:0] {
    PH_WAIT = 3'h1,
    PH_CRC  = 3'h2,
    PH_DONE = 3'h4
  } bmsd_phase_t;

  bmsd_phase_t phaseReg;
  bmsd_phase_t phaseNext;
  bmsd_pkg::bmsd_boot_t typeNext;
  logic [31:0] addrNext;

  always_comb begin
    phaseNext = phaseReg;
    typeNext  = bootType;
    addrNext  = exitJumpAddr;
    unique case (phaseReg)
      PH_WAIT: begin
        if (captured) begin
          typeNext = baseType;
          addrNext = exitAddrOf(baseType);
          phaseNext = isAlternate ? PH_CRC : PH_DONE;
        end
      end
      PH_CRC: begin
        if (crcDone) begin
          phaseNext = PH_DONE;
          if (crcPass) begin
            addrNext = altHeaderAddr;
          end else begin
            typeNext = bmsd_pkg::BMSD_LOADER1;
            addrNext = `BMSD_ADDR_LOADER;
          end
        end
      end
      PH_DONE: begin
        phaseNext = PH_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phaseReg      <= PH_WAIT;
      bootType      <= bmsd_pkg::BMSD_IDLE;
      bootCtrl      <= '0;
      exitJumpAddr  <= `BMSD_ADDR_NONE;
      busConfigAddr <= `BMSD_ADDR_NONE;
      tristateChip  <= 1'b0;
      stopLoop      <= 1'b0;
      crcRequest    <= 1'b0;
      bootValid     <= 1'b0;
    end else begin
      phaseReg      <= phaseNext;
      bootType      <= typeNext;
      exitJumpAddr  <= addrNext;
      bootCtrl      <= captured ? ctrlNext : '0;
      busConfigAddr <= (captured && isExternal) ? `BMSD_BUS_CFG_OFFSET : `BMSD_ADDR_NONE;
      tristateChip  <= (typeNext == bmsd_pkg::BMSD_TRISTATE);
      stopLoop      <= (typeNext == bmsd_pkg::BMSD_STOP);
      crcRequest    <= (phaseNext == PH_CRC);
      bootValid     <= (phaseNext == PH_DONE);
    end
  end

endmodule

/* bench/bmsd_props.sv */
`timescale 1ns/1ps
module bmsd_props (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 crcDone,
  input wire logic                 crcPass,
  input wire logic [31:0]          altHeaderAddr,
  input wire bmsd_pkg::bmsd_boot_t bootType,
  input wire bmsd_pkg::bmsd_ctrl_t bootCtrl,
  input wire logic [31:0]          exitJumpAddr,
  input wire logic [31:0]          busConfigAddr,
  input wire logic                 tristateChip,
  input wire logic                 stopLoop,
  input wire logic                 crcRequest,
  input wire logic                 bootValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_decide_in_time: assert property ($rose(rstn) |-> ##[1:3] (bootValid || crcRequest))
    else $error("no decision after reset release");
  a_hold_decision: assert property (bootValid |=> bootValid && $stable(bootType) && $stable(exitJumpAddr))
    else $error("decision changed");
  a_crc_pass_jump: assert property (crcRequest && crcDone && crcPass |=>
    bootValid && !crcRequest && exitJumpAddr == $past(altHeaderAddr)) else $error("crc pass jump wrong");
  a_crc_fail_loader: assert property (crcRequest && crcDone && !crcPass |=>
    bootType == bmsd_pkg::BMSD_LOADER1 && exitJumpAddr == 32'hD4000000) else $error("crc fallback wrong");
  a_crc_wait_holds: assert property (crcRequest && !crcDone |=> crcRequest && !bootValid)
    else $error("crc wait dropped");
  a_tristate_type: assert property (tristateChip |-> bootType == bmsd_pkg::BMSD_TRISTATE)
    else $error("tristate type wrong");
  a_stop_loop: assert property (stopLoop |-> bootType == bmsd_pkg::BMSD_STOP && bootValid)
    else $error("stop loop type wrong");
  a_ext_config: assert property (bootType == bmsd_pkg::BMSD_EXTMEM |->
    busConfigAddr == 32'h4 && bootCtrl.chipSelectZero) else $error("ext config wrong");
  a_flash_exit: assert property (bootValid && bootType == bmsd_pkg::BMSD_FLASH && !bootCtrl.crcCheck |->
    exitJumpAddr == 32'hA0000000) else $error("flash exit wrong");
endmodule

/* bench/bmsd_crc_model.sv */
`timescale 1ns/1ps
module bmsd_crc_model (
  input  wire logic        clk,
  input  wire logic        crcRequest,
  input  wire logic        passMode,
  input  wire logic [3:0]  lag,
  output logic             crcDone,
  output logic             crcPass,
  output logic [31:0]      altHeaderAddr
);
  logic [3:0] cnt;
  initial begin
    crcDone = 1'b0;
    crcPass = 1'b0;
    altHeaderAddr = 32'h0;
    cnt = 4'h0;
  end
  // verdict lines scramble once released, so a stale verdict never passes by luck
  always @(posedge clk) begin
    if (crcRequest && !crcDone && cnt == lag) begin
      crcDone <= 1'b1;
      crcPass <= passMode;
      altHeaderAddr <= 32'h80001230;
    end else begin
      crcDone <= 1'b0;
      crcPass <= ~crcPass;
      altHeaderAddr <= ~altHeaderAddr;
      cnt <= crcRequest ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

/* bench/tb_boot_mode_select_decoder.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_boot_mode_select_decoder;
  logic                 clk, rstn, breakInput, emulationPresent, passMode;
  logic [3:0]           hardwareConfigPins, lag;
  logic [2:0]           port0Pins;
  logic                 crcDone, crcPass, tristateChip, stopLoop, crcRequest, bootValid;
  logic [31:0]          altHeaderAddr, exitJumpAddr, busConfigAddr;
  bmsd_pkg::bmsd_boot_t bootType;
  bmsd_pkg::bmsd_ctrl_t bootCtrl;
  int                   err_total, total_checks;
  localparam logic [9:0] TYP [17] = '{10'h002, 10'h004, 10'h010, 10'h200, 10'h020, 10'h200, 10'h020, 10'h200,
    10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h008, 10'h040};
  localparam logic [31:0] ADR [17] = '{32'hD4000000, 32'h0, 32'hA0000000, 32'h0, 32'hA1000000, 32'h0,
    32'hA1000000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hD4000000, 32'hAFF00000};
  always #2 clk = ~clk;
  bmsd_boot_mode_select_decoder i_dut (.clk, .rstn, .breakInput, .hardwareConfigPins, .port0Pins,
    .emulationPresent, .crcDone, .crcPass, .altHeaderAddr, .bootType, .bootCtrl, .exitJumpAddr,
    .busConfigAddr, .tristateChip, .stopLoop, .crcRequest, .bootValid);
  bmsd_crc_model i_crc (.clk, .crcRequest, .passMode, .lag, .crcDone, .crcPass, .altHeaderAddr);
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // straps flip after capture: a late change must not leak into the decision
  task automatic reboot(input logic b, input logic [3:0] c, input logic e, input logic [2:0] p);
    @(posedge clk);
    rstn <= 1'b0;
    breakInput <= b;
    hardwareConfigPins <= c;
    emulationPresent <= e;
    port0Pins <= p;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    breakInput <= ~b;
    hardwareConfigPins <= ~c;
    port0Pins <= ~p;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_normal();
    logic [3:0] c;
    for (int i = 0; i < 17; i++) begin
      c = (i == 16) ? 4'h8 : i[3:0];
      if (i == 3 || i == 5 || i == 7) continue;
      reboot(1'b1, c, i == 16, 3'h5);
      `CHK(bootType, TYP[i])
      if (i != 1) `CHK(exitJumpAddr, ADR[i])
      `CHK(stopLoop, TYP[i] == 10'h200)
      `CHK(bootValid, 1'b1)
      `CHK(busConfigAddr, (c == 4'h4 || c == 4'h6) ? 32'h4 : 32'h0)
      `CHK(bootCtrl.busMaster, c == 4'h4)
      `CHK(bootCtrl.busParticipant, c == 4'h6)
      `CHK(bootCtrl.busAutoCfg, c == 4'h4 || c == 4'h6)
      `CHK(bootCtrl.crcCheck, 1'b0)
    end
  endtask
  task automatic t_debug();
    for (int i = 0; i < 3; i++) begin
      reboot(1'b0, (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : 4'h5, 1'b0, 3'h2);
      `CHK(tristateChip, i == 0)
      `CHK(stopLoop, i == 2)
      `CHK(exitJumpAddr, (i == 1) ? 32'hDE000000 : 32'h0)
      `CHK(bootCtrl.emulatorChipSelect, i == 1)
      `CHK(bootCtrl.busMaster, i == 1)
    end
  endtask
  task automatic t_alt();
    logic [3:0] c;
    for (int i = 0; i < 6; i++) begin
      c = 4'h3 + 4'h2 * i[2:1];
      passMode <= i[0];
      lag <= i[0] ? 4'h0 : 4'h8;
      reboot(1'b1, c, 1'b0, i[2:0]);
      if (!i[0]) `CHK(crcRequest, 1'b1)
      for (int k = 0; k < 20 && bootValid !== 1'b1; k++) @(posedge clk);
      #1;
      `CHK(bootType, i[0] ? ((c == 4'h3) ? 10'h010 : 10'h020) : 10'h002)
      `CHK(exitJumpAddr, i[0] ? 32'h80001230 : 32'hD4000000)
      `CHK(bootCtrl.fallbackLoader, i[2:0])
      `CHK(bootCtrl.crcCheck, 1'b1)
      `CHK(bootCtrl.busAutoCfg, c != 4'h3)
      `CHK(bootCtrl.busMaster, c == 4'h5)
      `CHK(bootCtrl.busParticipant, c == 4'h7)
      `CHK(busConfigAddr, (c != 4'h3) ? 32'h4 : 32'h0)
      `CHK(crcRequest, 1'b0)
    end
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {breakInput, emulationPresent, passMode, hardwareConfigPins, port0Pins, lag} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    t_normal();
    t_debug();
    t_alt();
    conclude();
  end
  initial begin
    #8000;
    err_total++;
    conclude();
  end
endmodule
bind bmsd_boot_mode_select_decoder bmsd_props i_props (.clk, .rstn, .crcDone, .crcPass, .altHeaderAddr,
  .bootType, .bootCtrl, .exitJumpAddr, .busConfigAddr, .tristateChip, .stopLoop, .crcRequest, .bootValid);
